// File: rtl/fdt_format_host.sv
// host-side generator of the whole-track format byte stream
// assumes the controller already holds a write-track command; its byte request
// and completion interrupt arrive asynchronously and are synchronised here
//
// Overview of operation
// - sector length is 128, 256, 512 or 1024 bytes, nothing else
// - single density id fields carry length code 00, 128 bytes
// - double density id fields carry length code 01, 256 bytes
// - side 00 or 01, track 00-4C, sector 01-1A in each id field
// - byte F7 after a field makes the controller write two crc bytes
// - the per-sector pattern repeats 26 times per track
// - single density track end: send FF until the completion interrupt
// - double density track end: send 4E until the completion interrupt
// - id-to-data gap counts are exact: 11 FF 6 00, or 22 4E 12 00 3 A1
// - other gaps are minimums; the three A1 sync bytes are exact
// - bytes F5 to FE never appear in gaps, id or data fields
`timescale 1ns/1ps
`default_nettype none
module fdt_format_host #(
   parameter int SECTORS = fdt_pkg::SECTORS_STD,
   parameter int FM_BYTES = fdt_pkg::FM_SECTOR_BYTES,
   parameter int MFM_BYTES = fdt_pkg::MFM_SECTOR_BYTES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // user command
   input wire logic start,
   input wire logic double_density,
   input wire logic [7:0] track,
   input wire logic [7:0] side,
   output logic busy,
   output logic format_done,
   output logic start_refused,
   // controller data port
   output logic [7:0] fmt_data,
   output logic fmt_wr,
   input wire logic byte_request_out,
   input wire logic completion_interrupt_out
);
   // only the four sizes the controller supports; fill bytes stay clear of marks
   generate
      if (!(FM_BYTES inside {128, 256, 512, 1024}) ||
          !(MFM_BYTES inside {128, 256, 512, 1024})) begin : g_bad_size
         $error("sector length must be 128, 256, 512 or 1024 bytes");
      end
      if (SECTORS < 1 || SECTORS > 26) begin : g_bad_count
         $error("sector count must be 1 to 26");
      end
   endgenerate

   typedef struct packed {
      fdt_pkg::fdt_state_e st;
      logic dd;
      logic [7:0] trk;
      logic [7:0] sid;
      logic [7:0] sec;
      logic phase_sect;
      logic [3:0] idx;
      logic [10:0] cnt;
      logic req1;
      logic req2;
      logic req_prev;
      logic irq1;
      logic irq2;
      logic [7:0] wdata;
      logic wr;
      logic busy;
      logic done;
      logic refused;
   } fdt_host_s;

   fdt_host_s q;
   fdt_host_s d;
   logic [7:0] seg_byte;
   logic [10:0] seg_len;
   logic gen_valid;
   logic push;
   logic adv;
   logic active;
   logic req_rise;
   logic flush;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [7:0] buf_out_data;

   // length code: 0 for 128 bytes up to 3 for 1024
   function automatic logic [7:0] len_code(input int bytes);
      return (bytes == 1024) ? 8'h03 : (bytes == 512) ? 8'h02 :
             (bytes == 256) ? 8'h01 : 8'h00;
   endfunction

   // one segment of the track: byte value and repeat count; count 0 is skipped
   function automatic logic [18:0] seg_info(input logic dd, input logic sect,
                                            input logic [3:0] i, input logic [7:0] trk,
                                            input logic [7:0] sid, input logic [7:0] sec);
      logic [7:0] fill;
      logic [7:0] b;
      int n;
      fill = dd ? fdt_pkg::MFM_FILL : fdt_pkg::FM_FILL;
      b = fill;
      n = 0;
      case ({sect, i})
         5'h00: begin b = fill; n = dd ? fdt_pkg::MFM_GAP5 : fdt_pkg::FM_GAP5; end
         5'h01: begin b = fdt_pkg::ZERO; n = dd ? fdt_pkg::MFM_ZEROS : fdt_pkg::FM_ZEROS; end
         5'h02: begin b = fdt_pkg::SYNC_C2_CODE; n = dd ? fdt_pkg::MFM_SYNC : 0; end
         5'h03: begin b = fdt_pkg::INDEX_MARK; n = 1; end
         5'h04: begin b = fill; n = dd ? fdt_pkg::MFM_GAP1 : fdt_pkg::FM_GAP1; end
         5'h10: begin b = fdt_pkg::ZERO; n = dd ? fdt_pkg::MFM_ZEROS : fdt_pkg::FM_ZEROS; end
         5'h11: begin b = fdt_pkg::SYNC_A1_CODE; n = dd ? fdt_pkg::MFM_SYNC : 0; end
         5'h12: begin b = fdt_pkg::ID_MARK; n = 1; end
         5'h13: begin b = trk; n = 1; end
         5'h14: begin b = sid; n = 1; end
         5'h15: begin b = sec; n = 1; end
         5'h16: begin b = dd ? len_code(MFM_BYTES) : len_code(FM_BYTES); n = 1; end
         5'h17: begin b = fdt_pkg::CRC_CODE; n = 1; end
         5'h18: begin b = fill; n = dd ? fdt_pkg::MFM_GAP2 : fdt_pkg::FM_GAP2; end
         5'h19: begin b = fdt_pkg::ZERO; n = dd ? fdt_pkg::MFM_ZEROS : fdt_pkg::FM_ZEROS; end
         5'h1A: begin b = fdt_pkg::SYNC_A1_CODE; n = dd ? fdt_pkg::MFM_SYNC : 0; end
         5'h1B: begin b = fdt_pkg::DATA_MARK; n = 1; end
         5'h1C: begin
            b = dd ? fdt_pkg::MFM_DATA_FILL : fdt_pkg::FM_DATA_FILL;
            n = dd ? MFM_BYTES : FM_BYTES;
         end
         5'h1D: begin b = fdt_pkg::CRC_CODE; n = 1; end
         5'h1E: begin b = fill; n = dd ? fdt_pkg::MFM_GAP3 : fdt_pkg::FM_GAP3; end
         default: begin b = fill; n = 0; end
      endcase
      return {b, 11'(n)};
   endfunction

   // current segment and the byte the generator offers
   always_comb begin
      {seg_byte, seg_len} = seg_info(q.dd, q.phase_sect, q.idx, q.trk, q.sid, q.sec);
      if (q.st == fdt_pkg::ST_FILL) begin
         seg_byte = q.dd ? fdt_pkg::MFM_FILL : fdt_pkg::FM_FILL;
      end
   end

   assign active = (q.st == fdt_pkg::ST_PRE) | (q.st == fdt_pkg::ST_SECT) |
                   (q.st == fdt_pkg::ST_FILL);
   assign gen_valid = (q.st == fdt_pkg::ST_FILL) | (active & (seg_len != '0));
   assign push = gen_valid & buf_in_ready;
   assign adv = (q.st != fdt_pkg::ST_FILL) & active & (push | (seg_len == '0));
   // one byte per request edge; the controller drops its request after each write
   assign req_rise = q.req2 & ~q.req_prev;
   assign buf_out_ready = active & req_rise & ~q.irq2;
   assign flush = active & q.irq2;

   // buffer lets the generator run ahead without losing a byte to a slow request
   fdt_skid_buf #(.W(8), .DEPTH(2)) u_buf (
      .clk(clk),
      .rst_n(rst_n),
      .flush(flush),
      .in_valid(gen_valid),
      .in_data(seg_byte),
      .in_ready(buf_in_ready),
      .out_valid(buf_out_valid),
      .out_data(buf_out_data),
      .out_ready(buf_out_ready)
   );

   // sequencing, pin synchronisers and the write strobe
   always_comb begin
      d = q;
      d.req1 = byte_request_out;
      d.req2 = q.req1;
      d.req_prev = q.req2;
      d.irq1 = completion_interrupt_out;
      d.irq2 = q.irq1;
      d.wr = 1'b0;
      d.done = 1'b0;
      d.refused = 1'b0;
      if (buf_out_ready && buf_out_valid) begin
         d.wdata = buf_out_data;
         d.wr = 1'b1;
      end
      if (adv) begin
         if (push && (q.cnt + 11'd1 < seg_len)) begin
            d.cnt = q.cnt + 11'd1;
         end else begin
            d.cnt = '0;
            d.idx = q.idx + 4'd1;
            if (!q.phase_sect && q.idx == fdt_pkg::SEG_PRE_LAST) begin
               d.st = fdt_pkg::ST_SECT;
               d.phase_sect = 1'b1;
               d.idx = '0;
            end else if (q.phase_sect && q.idx == fdt_pkg::SEG_SECT_LAST) begin
               d.idx = '0;
               if (q.sec == 8'(SECTORS)) begin
                  d.st = fdt_pkg::ST_FILL;
               end else begin
                  d.sec = q.sec + 8'd1;
               end
            end
         end
      end
      case (q.st)
         fdt_pkg::ST_IDLE: begin
            // a stale interrupt would end the new track at once, so refuse then
            if (start) begin
               if (track > fdt_pkg::TRACK_MAX || side > fdt_pkg::SIDE_MAX || q.irq2) begin
                  d.refused = 1'b1;
               end else begin
                  d.st = fdt_pkg::ST_PRE;
                  d.busy = 1'b1;
                  d.dd = double_density;
                  d.trk = track;
                  d.sid = side;
                  d.sec = fdt_pkg::SECTOR_FIRST;
                  d.phase_sect = 1'b0;
                  d.idx = '0;
                  d.cnt = '0;
               end
            end
         end
         fdt_pkg::ST_PRE, fdt_pkg::ST_SECT, fdt_pkg::ST_FILL: begin
            // the controller ends the track at the second index pulse
            if (q.irq2) begin
               d.st = fdt_pkg::ST_IDLE;
               d.busy = 1'b0;
               d.done = 1'b1;
            end
         end
         default: begin
            d.st = fdt_pkg::ST_IDLE;
            d.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
         q.st <= fdt_pkg::ST_IDLE;
      end else begin
         q <= d;
      end
   end

   assign fmt_data = q.wdata;
   assign fmt_wr = q.wr;
   assign busy = q.busy;
   assign format_done = q.done;
   assign start_refused = q.refused;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_crc_code_sent: assert property (push && q.phase_sect && q.idx == fdt_pkg::SEG_ID_CRC
      |-> seg_byte == fdt_pkg::CRC_CODE) else $error("id crc code wrong");
   a_len_code_ok: assert property (push && q.phase_sect && q.idx == fdt_pkg::SEG_LEN
      |-> seg_byte == (q.dd ? 8'h01 : 8'h00)) else $error("length code wrong");
   a_id_in_range: assert property (push && q.phase_sect && q.idx == fdt_pkg::SEG_SECTOR
      |-> q.sec >= 8'h01 && q.sec <= 8'h1A && q.trk <= 8'h4C && q.sid <= 8'h01)
      else $error("id field out of range");
   a_sector_total: assert property (q.st == fdt_pkg::ST_SECT ##1 q.st == fdt_pkg::ST_FILL
      |-> $past(q.sec) == 8'(SECTORS)) else $error("wrong sector total");
   a_fill_value: assert property (push && q.st == fdt_pkg::ST_FILL
      |-> seg_byte == (q.dd ? 8'h4E : 8'hFF)) else $error("track end fill wrong");
   a_gap2_exact: assert property (adv && q.phase_sect && q.idx == fdt_pkg::SEG_GAP2
      && d.idx != q.idx |-> q.cnt == (q.dd ? 11'd21 : 11'd10)) else $error("id gap count wrong");
   a_sync_exact: assert property (adv && q.phase_sect && q.idx == fdt_pkg::SEG_SYNC1
      && q.dd && d.idx != q.idx |-> q.cnt == 11'd2 ##1 q.idx == 4'h2) else $error("sync count");
   a_data_size: assert property (adv && q.phase_sect && q.idx == fdt_pkg::SEG_DATA
      && d.idx != q.idx |-> q.cnt == 11'(q.dd ? MFM_BYTES - 1 : FM_BYTES - 1))
      else $error("sector size");
   a_no_mark_data: assert property (push && q.phase_sect && q.idx == fdt_pkg::SEG_DATA
      |-> !(seg_byte inside {[8'hF5:8'hFE]})) else $error("mark code in data");
   a_irq_ends: assert property (active && q.irq2 |=> !busy && format_done && !fmt_wr)
      else $error("interrupt did not end the format");

   c_track_done: cover property (q.st == fdt_pkg::ST_FILL ##[1:1000] format_done);
   c_refused: cover property (start_refused);
   c_dd_sync: cover property (fmt_wr && fmt_data == fdt_pkg::SYNC_A1_CODE);
endmodule
`default_nettype wire

// File: rtl/fdt_pkg.sv
// constants for the host-side whole-track format byte generator
// assumes one 50 MHz clock; used by fdt_format_host only, not by its buffer
package fdt_pkg;
   // byte values passed to the controller
   localparam logic [7:0] FM_FILL = 8'hFF;
   localparam logic [7:0] MFM_FILL = 8'h4E;
   localparam logic [7:0] ZERO = 8'h00;
   localparam logic [7:0] INDEX_MARK = 8'hFC;
   localparam logic [7:0] ID_MARK = 8'hFE;
   localparam logic [7:0] DATA_MARK = 8'hFB;
   localparam logic [7:0] CRC_CODE = 8'hF7;
   localparam logic [7:0] SYNC_A1_CODE = 8'hF5;
   localparam logic [7:0] SYNC_C2_CODE = 8'hF6;
   localparam logic [7:0] FM_DATA_FILL = 8'hE5;
   localparam logic [7:0] MFM_DATA_FILL = 8'h40;
   localparam logic [7:0] MARK_LOW = 8'hF5;
   localparam logic [7:0] MARK_HIGH = 8'hFE;
   // legal id field contents
   localparam logic [7:0] TRACK_MAX = 8'h4C;
   localparam logic [7:0] SIDE_MAX = 8'h01;
   localparam logic [7:0] SECTOR_FIRST = 8'h01;
   localparam int SECTORS_STD = 26;
   // single density byte counts
   localparam int FM_GAP5 = 40;
   localparam int FM_ZEROS = 6;
   localparam int FM_GAP1 = 26;
   localparam int FM_GAP2 = 11;
   localparam int FM_GAP3 = 27;
   localparam int FM_SECTOR_BYTES = 128;
   // double density byte counts
   localparam int MFM_GAP5 = 80;
   localparam int MFM_ZEROS = 12;
   localparam int MFM_SYNC = 3;
   localparam int MFM_GAP1 = 50;
   localparam int MFM_GAP2 = 22;
   localparam int MFM_GAP3 = 54;
   localparam int MFM_SECTOR_BYTES = 256;
   // positions inside the per-sector segment list; SEG_PRE_LAST is in the preamble list
   localparam logic [3:0] SEG_SYNC1 = 4'h1;
   localparam logic [3:0] SEG_TRACK = 4'h3;
   localparam logic [3:0] SEG_SIDE = 4'h4;
   localparam logic [3:0] SEG_SECTOR = 4'h5;
   localparam logic [3:0] SEG_LEN = 4'h6;
   localparam logic [3:0] SEG_ID_CRC = 4'h7;
   localparam logic [3:0] SEG_GAP2 = 4'h8;
   localparam logic [3:0] SEG_DATA = 4'hC;
   localparam logic [3:0] SEG_SECT_LAST = 4'hE;
   localparam logic [3:0] SEG_PRE_LAST = 4'h4;
   // generator states
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_PRE = 5'h02,
      ST_SECT = 5'h04,
      ST_FILL = 5'h08,
      ST_SPARE = 5'h10
   } fdt_state_e;
endpackage

// File: rtl/fdt_skid_buf.sv
// two-entry byte buffer between the format generator and the controller port
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module fdt_skid_buf #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("buffer depth must be a power of two, at least two");
      end
   endgenerate

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fdt_buf_s;

   fdt_buf_s q;
   fdt_buf_s d;
   logic push;
   logic pop;

   // honest flags straight from the occupancy count
   assign in_ready = (q.cnt < (AW+1)'(DEPTH));
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rp];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // pointer and count update; flush drops everything held
   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wp] = in_data;
         d.wp = q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = q.rp + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         d.wp = '0;
         d.rp = '0;
         d.cnt = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   a_buf_no_overrun: assert property (@(posedge clk) disable iff (!rst_n)
      q.cnt <= (AW+1)'(DEPTH)) else $error("buffer count above depth");
endmodule
`default_nettype wire

// File: testbench/fdt_ctl_model.sv
// behavioural model of the disk controller taking whole-track format bytes
// assumes the host answers each byte request with a one-cycle write strobe
`timescale 1ns/1ps
`default_nettype none
module fdt_ctl_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bench control
   input wire logic en,
   input wire logic slow,
   input wire logic irq_clr,
   input wire logic double_density,
   input wire logic [15:0] n_bytes,
   // host data port
   input wire logic [7:0] fmt_data,
   input wire logic fmt_wr,
   output logic byte_request_out,
   output logic completion_interrupt_out,
   // what reached the disk
   output int wr_cnt,
   output int crc_pairs,
   output int mark_cnt,
   output int disk_cnt
);
   int k;
   int field_len;
   // one request at a time; request held until the strobe is seen or 20 cycles pass
   initial begin
      byte_request_out = 1'b0;
      completion_interrupt_out = 1'b0;
      wr_cnt = 0;
      crc_pairs = 0;
      mark_cnt = 0;
      disk_cnt = 0;
      field_len = 0;
      forever begin
         @(negedge clk);
         if (irq_clr) begin
            completion_interrupt_out = 1'b0;
            wr_cnt = 0;
            crc_pairs = 0;
            mark_cnt = 0;
            disk_cnt = 0;
         end
         if (en && rst_n && !completion_interrupt_out) begin
            byte_request_out = 1'b1;
            k = 0;
            do begin
               @(negedge clk);
               k++;
            end while (fmt_wr !== 1'b1 && k < 20);
            byte_request_out = 1'b0;
            if (fmt_wr === 1'b1) begin
               wr_cnt++;
               field_len++;
               disk_cnt++;
               // crc code is swapped for the two accumulated crc bytes
               if (fmt_data == 8'hF7) begin
                  crc_pairs++;
                  disk_cnt++;
               end
               // missing-clock sync bytes count as marks in double density; only F5 restarts the crc
               if (double_density && (fmt_data == 8'hF5 || fmt_data == 8'hF6)) begin
                  mark_cnt++;
                  if (fmt_data == 8'hF5) field_len = 0;
               end
               if (!double_density && fmt_data >= 8'hF8 && fmt_data <= 8'hFE) field_len = 0;
               // the last awaited byte stands in for the next index pulse
               if (wr_cnt == int'(n_bytes)) completion_interrupt_out = 1'b1;
            end
            // request must be seen low before it rises again
            repeat (slow ? 3 + wr_cnt % 5 : 3) @(negedge clk);
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench/disk_track_format_stream_test.sv
// self-checking bench for the track format byte generator
// assumes a controller model on the far side and a byte-by-byte reference
`timescale 1ns/1ps
`default_nettype none
module disk_track_format_stream_test;
   localparam int S = 2;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic start = 1'b0;
   logic double_density = 1'b0;
   logic [7:0] track = 8'h00;
   logic [7:0] side = 8'h00;
   logic busy, format_done, start_refused, fmt_wr;
   logic [7:0] fmt_data, fill;
   logic byte_request_out, completion_interrupt_out;
   logic en = 1'b0;
   logic slow = 1'b0;
   logic irq_clr = 1'b0;
   logic [15:0] n_bytes = 16'h0000;
   int wr_cnt, crc_pairs, mark_cnt, disk_cnt;
   int bad_count = 0;
   int checks = 0;
   int seed = 19292;
   logic [7:0] exp_q[$];
   always #10 clk = ~clk;
   fdt_format_host #(.SECTORS(S)) DUT (.clk(clk), .rst_n(rst_n), .start(start),
      .double_density(double_density), .track(track), .side(side), .busy(busy),
      .format_done(format_done), .start_refused(start_refused), .fmt_data(fmt_data),
      .fmt_wr(fmt_wr), .byte_request_out(byte_request_out),
      .completion_interrupt_out(completion_interrupt_out));
   fdt_ctl_model ctl (.clk(clk), .rst_n(rst_n), .en(en), .slow(slow), .irq_clr(irq_clr),
      .double_density(double_density), .n_bytes(n_bytes), .fmt_data(fmt_data),
      .fmt_wr(fmt_wr), .byte_request_out(byte_request_out),
      .completion_interrupt_out(completion_interrupt_out), .wr_cnt(wr_cnt),
      .crc_pairs(crc_pairs), .mark_cnt(mark_cnt), .disk_cnt(disk_cnt));
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic put(input logic [7:0] v, input int n);
      repeat (n) exp_q.push_back(v);
   endtask
   // reference byte order for one whole track
   task automatic build(input logic dd, input logic [7:0] t, input logic [7:0] s);
      int nz, ns;
      nz = dd ? 12 : 6;
      ns = dd ? 3 : 0;
      put(fill, dd ? 80 : 40);
      put(8'h00, nz);
      put(8'hF6, ns);
      put(8'hFC, 1);
      put(fill, dd ? 50 : 26);
      for (int sec = 1; sec <= S; sec++) begin
         put(8'h00, nz);
         put(8'hF5, ns);
         put(8'hFE, 1);
         put(t, 1);
         put(s, 1);
         put(8'(sec), 1);
         put(dd ? 8'h01 : 8'h00, 1);
         put(8'hF7, 1);
         put(fill, dd ? 22 : 11);
         put(8'h00, nz);
         put(8'hF5, ns);
         put(8'hFB, 1);
         put(dd ? 8'h40 : 8'hE5, dd ? 256 : 128);
         put(8'hF7, 1);
         put(fill, dd ? 54 : 27);
      end
   endtask
   // every written byte against the reference, then fill; looked at mid-cycle
   always @(negedge clk) begin
      if (fmt_wr === 1'b1) begin
         if (exp_q.size() > 0) cmp("stream byte", exp_q.pop_front(), fmt_data);
         else cmp("fill byte", fill, fmt_data);
      end
   end
   task automatic try_start(input logic [7:0] t, input logic [7:0] s);
      @(negedge clk);
      track = t;
      side = s;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
   endtask
   task automatic run(input logic dd, input logic sl);
      int i, n;
      logic [7:0] t, s;
      t = 8'($unsigned($random(seed)) % 77);
      s = 8'($unsigned($random(seed)) % 2);
      exp_q.delete();
      fill = dd ? 8'h4E : 8'hFF;
      double_density = dd;
      build(dd, t, s);
      n = exp_q.size() + 6;
      n_bytes = 16'(n);
      slow = sl;
      en = 1'b1;
      try_start(t, s);
      cmp("busy after start", 1'b1, busy);
      i = 0;
      while (format_done !== 1'b1 && i < 30000) begin
         @(negedge clk);
         i++;
      end
      cmp("done pulse", 1'b1, format_done);
      cmp("host bytes", n, wr_cnt);
      cmp("crc pairs", 2 * S, crc_pairs);
      cmp("disk bytes", n + S * 2, disk_cnt);
      cmp("sync marks", dd ? 6 * S + 3 : 0, mark_cnt);
      cmp("left over", 0, exp_q.size());
      @(negedge clk);
      cmp("busy after done", 1'b0, busy);
      en = 1'b0;
      $display("test done: density %0d track %0h side %0h", dd, t, s);
   endtask
   task automatic test_done;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      test_done;
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      run(1'b0, 1'b0);
      // stale interrupt still high: a legal start is turned away
      try_start(8'h10, 8'h00);
      cmp("stale refused", 1'b1, start_refused);
      @(negedge clk);
      irq_clr = 1'b1;
      repeat (2) @(negedge clk);
      irq_clr = 1'b0;
      repeat (4) @(negedge clk);
      // id field ranges at their edges
      try_start(8'h4D, 8'h00);
      cmp("track refused", 1'b1, start_refused);
      cmp("idle after track", 1'b0, busy);
      try_start(8'h4C, 8'h02);
      cmp("side refused", 1'b1, start_refused);
      $display("test done: refusals");
      run(1'b1, 1'b1);
      test_done;
   end
endmodule
`default_nettype wire
